// *** ssp_host.sv ***
// Purpose: Host model that drives the three-wire write port
// Assumes: Link clock period 125 ns, with no phase relation to core_clk
// Notes:   Released data is inverted so that a stale bit never looks valid
`timescale 1ns/100ps
module ssp_host
(
  // Serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic load_latch_strobe
);
  // Idle: clock low, strobe high
  initial
  begin
    ser_clk           = 1'b0;
    ser_data          = 1'b0;
    load_latch_strobe = 1'b1;
  end

  // One link clock period, data set a quarter period before the rising edge
  task automatic bit_out(input logic b);
    ser_data = b;
    #31.25 ser_clk = 1'b1;
    #62.5 ser_clk = 1'b0;
    #31.25;
  endtask

  // The clock is already low when the strobe falls
  task automatic open_frame();
    load_latch_strobe = 1'b0;
    #100;
  endtask

  // Release the data line and raise the strobe
  task automatic latch();
    ser_data = ~ser_data;
    #62.5 load_latch_strobe = 1'b1;
    #300;
  endtask

  // Whole word, most significant bit first
  task automatic send(input logic [31:0] w);
    if (load_latch_strobe)
      open_frame();
    for (int i = 31; i >= 0; i--)
      bit_out(w[i]);
    latch();
  endtask

  // Clock pulses while the strobe stays high
  task automatic idle_pulses(input int n);
    for (int i = 0; i < n; i++)
      bit_out(~ser_data);
  endtask
endmodule

// *** ssp_pkg.sv ***
// Purpose: Shared constants and types for the serial program port
// Assumes: 100 MHz core clock; 32-bit words, 4-bit address, 28-bit data
// Notes:   Field positions are counted inside the 28-bit data field
package ssp_pkg;

  // Word layout
  localparam int SSP_WORD_W = 32;
  localparam int SSP_ADDR_W = 4;
  localparam int SSP_DATA_W = 28;
  localparam int SSP_NREGS  = 16;

  // Timing
  localparam int SSP_CLK_PERIOD_NS = 10;
  localparam int SSP_RESET_TIME_NS = 1000;
  // Longest time, so it rounds down
  localparam int SSP_RESET_CYC     = SSP_RESET_TIME_NS / SSP_CLK_PERIOD_NS;

  // Register addresses
  localparam logic [3:0] SSP_REG_R0  = 4'h0;
  localparam logic [3:0] SSP_REG_FST = 4'h4;
  localparam logic [3:0] SSP_REG_R5  = 4'h5;

  // Addresses that hold storage: 0..10, 13 and 15
  localparam logic [15:0] SSP_IMPL_MASK = 16'ha7ff;

  // Field positions within the data field
  localparam int SSP_RESET_BIT = 0;
  localparam int SSP_PWDN_LSB  = 1;
  localparam int SSP_MODE_BIT  = 3;
  localparam int SSP_SKIPCAL_BIT = 9;
  localparam int SSP_FST_LSB   = 0;
  localparam int SSP_FST_W     = 12;

  // Values after reset
  localparam logic [27:0] SSP_WORD_DEFAULT = 28'h0000000;

  typedef logic [27:0] ssp_word_t;
  typedef ssp_word_t [15:0] ssp_bank_t;

  // Powerdown selection codes
  typedef enum logic [1:0]
  {
    SSP_PWR_ON      = 2'b00,
    SSP_PWR_PARTIAL = 2'b01,
    SSP_PWR_FULL    = 2'b10
  } ssp_pwr_state_t;

  // Power switches of the analog sections
  typedef struct packed
  {
    logic osc_on;
    logic loop_on;
    logic outbuf_on;
    logic regulator_on;
  } ssp_pwr_t;

  // Pins sampled from outside the core clock domain; the strobe travels
  // inverted so that the filter's all-zero reset matches an idle host
  typedef struct packed
  {
    logic sclk;        // Serial clock level
    logic sdata;       // Serial data level
    logic frame_open;  // Load strobe low: a word is being shifted
    logic enable;      // Enable pin level
  } ssp_pins_t;

endpackage

// *** ssp_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to core_clk
// Notes:   Output follows once stages two and three agree
`timescale 1ns/100ps
module ssp_sync
#(
  parameter int W = 4
)
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;   // Metastable stage, read only by s2_r
  logic [W-1:0] s2_r;   // Second stage
  logic [W-1:0] s3_r;   // Third stage
  logic [W-1:0] out_nxt;
  logic [W-1:0] out_r;  // Filtered level

  // Per bit: take the new level only when two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_comb
      begin
        out_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : out_r[gi];
      end
    end
  endgenerate

  // Stage registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end
    else
    begin
      s1_r  <= din;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;

endmodule

// *** ssp_top.sv ***
// Purpose: Three-wire write port and mode control of a synthesizer
// Assumes: Host clock, data and strobe are far slower than core_clk
// Notes:   Pins are oversampled; the serial clock is not a clock domain
// Notes on behaviour
// - Shift register stages; config unchanged while shifting
// - Low four bits select target register
// - Upper 28 bits are written data
// - Sample data on rising clock, MSB first
// - Strobe rise copies data into addressed register
// - Strobe held high ignores serial clocks
// - Full or partial powerdown via word; full powerdown via pin
// - Partial powerdown keeps regulators on
// - Full powerdown switches everything off
// - Mode word selects internal or external oscillator
// - Reset bit restores defaults, then clears
// - Register zero write starts calibration, fast settle
`timescale 1ns/100ps
module ssp_top
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Serial pins from the host
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  input  wire logic              load_latch_strobe,
  input  wire logic              device_enable_pin,
  // Configuration state
  output ssp_pkg::ssp_bank_t     cfg_bank,
  output ssp_pkg::ssp_pwr_t      pwr_ctl,
  output logic                   ext_vco_select,
  // One-cycle action pulses
  output logic                   freq_cal_start,
  output logic                   fast_settle_engage
);
  import ssp_pkg::*;

  localparam int rst_bound = SSP_RESET_CYC;

  // Reset release synchroniser
  logic rst_meta_r;
  logic rst_s_n;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_s_n    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_s_n    <= rst_meta_r;
    end
  end

  // Pin sampling
  ssp_pins_t pins_raw;   // Raw pin levels
  ssp_pins_t pins_q;     // Filtered levels

  // Strobe is inverted here: zero after reset then means strobe high, so
  // no false load edge appears while the filter fills after reset
  assign pins_raw = '{sclk: ser_clk, sdata: ser_data, frame_open: ~load_latch_strobe,
                      enable: device_enable_pin};

  ssp_sync #(.W(4)) u_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_s_n),
    .din      (pins_raw),
    .dout     (pins_q)
  );

  // Edge detection state
  logic sclk_d_r;
  logic open_d_r;    // Frame open level one cycle ago
  logic sclk_rise;
  logic load_rise;   // Strobe rose: frame just closed

  // Clock and data pass through the same filter, so they stay aligned
  assign sclk_rise = pins_q.sclk & ~sclk_d_r;
  assign load_rise = ~pins_q.frame_open & open_d_r;

  // Staging shift register and register bank
  logic [31:0] shift_r;       // Staging word
  logic [31:0] shift_nxt;
  ssp_bank_t   bank_r;        // Configuration registers
  ssp_bank_t   bank_nxt;
  logic [3:0]  wr_addr;       // Address field of staged word
  ssp_word_t   wr_data;       // Data field of staged word
  logic        wr_impl;       // Address names stored register
  logic        r0_write;      // Strobe loads register zero

  assign wr_addr  = shift_r[SSP_ADDR_W-1:0];
  assign wr_data  = shift_r[SSP_WORD_W-1:SSP_ADDR_W];
  assign wr_impl  = SSP_IMPL_MASK[wr_addr];
  assign r0_write = load_rise && (wr_addr == SSP_REG_R0);

  // Next shift word and bank contents
  always_comb
  begin
    shift_nxt = shift_r;
    bank_nxt  = bank_r;
    // Bits enter at the bottom, so the first bit ends up as MSB
    if (sclk_rise && pins_q.frame_open)
    begin
      shift_nxt = {shift_r[30:0], pins_q.sdata};
    end
    // Bank only moves on the strobe edge, never during shifting
    if (load_rise && wr_impl)
    begin
      if (wr_addr == SSP_REG_R5 && wr_data[SSP_RESET_BIT])
      begin
        // Defaults hold the reset bit at zero, so it clears itself
        for (int i = 0; i < SSP_NREGS; i++)
        begin
          bank_nxt[i] = SSP_WORD_DEFAULT;
        end
      end
      else
      begin
        bank_nxt[wr_addr] = wr_data;
      end
    end
  end

  // Power and mode decode
  ssp_pwr_state_t pwr_state;   // Effective powerdown state
  ssp_pwr_t       pwr_nxt;
  logic           freq_cal_nxt;
  logic           fast_settle_nxt;
  logic           ext_vco_nxt;

  always_comb
  begin
    // A low enable pin forces full powerdown over the word
    if (!pins_q.enable)
    begin
      pwr_state = SSP_PWR_FULL;
    end
    else
    begin
      unique case (bank_r[SSP_REG_R5][SSP_PWDN_LSB +: 2])
        2'b00:   pwr_state = SSP_PWR_ON;
        2'b01:   pwr_state = SSP_PWR_PARTIAL;
        2'b10:   pwr_state = SSP_PWR_FULL;
        // Spare code is treated as the safest state
        default: pwr_state = SSP_PWR_FULL;
      endcase
    end
    unique case (pwr_state)
      SSP_PWR_ON:      pwr_nxt = 4'b1111;
      SSP_PWR_PARTIAL: pwr_nxt = 4'b0001;
      SSP_PWR_FULL:    pwr_nxt = 4'b0000;
      default:         pwr_nxt = 4'b0000;
    endcase
    ext_vco_nxt     = bank_r[SSP_REG_R5][SSP_MODE_BIT];
    freq_cal_nxt    = r0_write && !wr_data[SSP_SKIPCAL_BIT];
    fast_settle_nxt = r0_write && (bank_r[SSP_REG_FST][SSP_FST_LSB +: SSP_FST_W] != '0);
  end

  // State registers
  always_ff @(posedge core_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      sclk_d_r           <= 1'b0;
      open_d_r           <= 1'b0;
      shift_r            <= '0;
      bank_r             <= {SSP_NREGS{SSP_WORD_DEFAULT}};
      pwr_ctl            <= '0;
      ext_vco_select     <= 1'b0;
      freq_cal_start     <= 1'b0;
      fast_settle_engage <= 1'b0;
    end
    else
    begin
      sclk_d_r           <= pins_q.sclk;
      open_d_r           <= pins_q.frame_open;
      shift_r            <= shift_nxt;
      bank_r             <= bank_nxt;
      pwr_ctl            <= pwr_nxt;
      ext_vco_select     <= ext_vco_nxt;
      freq_cal_start     <= freq_cal_nxt;
      fast_settle_engage <= fast_settle_nxt;
    end
  end

  assign cfg_bank = bank_r;

  // Checks
  shift_hold_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      !pins_q.frame_open && !open_d_r |=> $stable(shift_r))
    else $error("shift register moved while strobe high");

  bank_quiet_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      !load_rise |=> $stable(bank_r))
    else $error("bank changed without strobe edge");

  shift_order_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      sclk_rise && pins_q.frame_open |=>
        shift_r[0] == $past(pins_q.sdata) && shift_r[31:1] == $past(shift_r[30:0]))
    else $error("serial bit not shifted in at bottom");

  load_word_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      load_rise && wr_impl && wr_addr != SSP_REG_R5 |=>
        bank_r[$past(wr_addr)] == $past(wr_data))
    else $error("strobe did not load addressed register");

  unmapped_hold_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      load_rise && !wr_impl |=> $stable(bank_r))
    else $error("unmapped address changed the bank");

  reset_clear_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      load_rise && wr_addr == SSP_REG_R5 && wr_data[SSP_RESET_BIT] |->
        ##[1:rst_bound] (bank_r[SSP_REG_R5] == SSP_WORD_DEFAULT
                         && bank_r[SSP_REG_R0] == SSP_WORD_DEFAULT))
    else $error("reset bit did not restore defaults in time");

  fcal_pulse_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      r0_write && !wr_data[SSP_SKIPCAL_BIT] |=> freq_cal_start ##1 !freq_cal_start)
    else $error("calibration start pulse missing or too long");

  full_off_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      !pins_q.enable |=> pwr_ctl == 4'b0000)
    else $error("enable pin low did not fully power down");

  partial_regs_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      pwr_state == SSP_PWR_PARTIAL |=> pwr_ctl.regulator_on && !pwr_ctl.osc_on
        && !pwr_ctl.loop_on && !pwr_ctl.outbuf_on)
    else $error("partial powerdown power switches wrong");

  vco_source_a:
    assert property (@(posedge core_clk) disable iff (!rst_s_n)
      ##1 ext_vco_select == $past(bank_r[SSP_REG_R5][SSP_MODE_BIT]))
    else $error("oscillator source does not follow mode bit");

endmodule

// *** tb_ssp_top.sv ***
// Purpose: Self-checking bench for the serial program port
// Assumes: Host model timing; checks wait 300 ns after each strobe rise
// Notes:   The expected bank is kept here from the written words alone
`timescale 1ns/100ps
module tb_ssp_top;
  import ssp_pkg::*;

  logic      core_clk;
  logic      rst_n;
  logic      device_enable_pin;
  logic      ser_clk;
  logic      ser_data;
  logic      load_latch_strobe;
  ssp_bank_t cfg_bank;
  ssp_bank_t exp_bank;          // Expected register contents
  ssp_pwr_t  pwr_ctl;
  logic      ext_vco_select;
  logic      freq_cal_start;
  logic      fast_settle_engage;
  int        num_errors   = 0;
  int        check_count  = 0;
  int        cal_count    = 0;  // Calibration pulses seen
  int        settle_count = 0;  // Fast settle pulses seen
  logic [3:0] unmapped [3] = '{4'hb, 4'hc, 4'he};
  logic [3:0] pwr_exp  [4] = '{4'hf, 4'h1, 4'h0, 4'h0};
  logic [3:0] init_seq [13] = '{4'hf, 4'hd, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6,
                                4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};

  ssp_host i_ssp_host (.ser_clk(ser_clk), .ser_data(ser_data),
                       .load_latch_strobe(load_latch_strobe));

  ssp_top i_ssp_top (.core_clk(core_clk), .rst_n(rst_n), .ser_clk(ser_clk),
                     .ser_data(ser_data), .load_latch_strobe(load_latch_strobe),
                     .device_enable_pin(device_enable_pin), .cfg_bank(cfg_bank),
                     .pwr_ctl(pwr_ctl), .ext_vco_select(ext_vco_select),
                     .freq_cal_start(freq_cal_start),
                     .fast_settle_engage(fast_settle_engage));

  // 100 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pulses last one cycle, so count them at every edge
  always @(posedge core_clk)
  begin
    if (freq_cal_start === 1'b1)
      cal_count++;
    if (fast_settle_engage === 1'b1)
      settle_count++;
  end

  task automatic check(input string what, input logic [447:0] seen, input logic [447:0] expv);
    check_count++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // Write one word and compare the whole bank
  task automatic wr(input logic [3:0] a, input logic [27:0] d);
    i_ssp_host.send({d, a});
    if (a == SSP_REG_R5 && d[SSP_RESET_BIT])
      exp_bank = '0;
    else if (SSP_IMPL_MASK[a])
      exp_bank[a] = d;
    check("cfg_bank", cfg_bank, exp_bank);
  endtask

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 150 us the tests need
  initial
  begin
    #1000000;
    num_errors++;
    stop_test();
  end

  initial
  begin
    rst_n             = 1'b0;
    device_enable_pin = 1'b1;
    exp_bank          = '0;
    repeat (3) @(posedge core_clk);
    check("reset pwr", pwr_ctl, 4'h0);
    @(posedge core_clk) #1 rst_n = 1'b1;
    repeat (30) @(posedge core_clk);
    check("pwr on", pwr_ctl, 4'hf);
    wr(4'h2, 28'habcdef1);
    wr(4'hf, 28'h5a5a5a5);
    // Extra leading bits fall out; the bank holds while shifting
    i_ssp_host.open_frame();
    for (int i = 0; i < 4; i++)
      i_ssp_host.bit_out(1'b1);
    check("mid shift", cfg_bank, exp_bank);
    wr(4'h7, 28'h0123456);
    // Pulses with the strobe high must not move the shift register
    i_ssp_host.idle_pulses(40);
    check("held strobe", cfg_bank, exp_bank);
    i_ssp_host.open_frame();
    for (int i = 3; i >= 0; i--)
      i_ssp_host.bit_out(i < 2);
    i_ssp_host.latch();
    exp_bank[3] = 28'h1234567;
    check("short word", cfg_bank, exp_bank);
    foreach (unmapped[k])
      wr(unmapped[k], 28'hfffffff);
    // Register zero triggers with and without calibration
    wr(SSP_REG_FST, 28'h0000005);
    cal_count    = 0;
    settle_count = 0;
    wr(SSP_REG_R0, 28'h0000000);
    wr(SSP_REG_R0, 28'h0000200);
    wr(SSP_REG_FST, 28'h0000000);
    wr(SSP_REG_R0, 28'h0000000);
    check("cal pulses", cal_count, 2);
    check("settle pulses", settle_count, 2);
    // Every powerdown code, oscillator source toggling each time
    for (int c = 3; c >= 0; c--)
    begin
      wr(SSP_REG_R5, {24'h0, c[0], c[1:0], 1'b0});
      repeat (5) @(posedge core_clk);
      check("pwr_ctl", pwr_ctl, pwr_exp[c]);
      check("ext_vco_select", ext_vco_select, c[0]);
    end
    @(posedge core_clk) #1 device_enable_pin = 1'b0;
    repeat (30) @(posedge core_clk);
    check("pin down", pwr_ctl, 4'h0);
    @(posedge core_clk) #1 device_enable_pin = 1'b1;
    repeat (30) @(posedge core_clk);
    // Full power-on sequence after leaving full powerdown
    wr(SSP_REG_R5, 28'h0000001);
    foreach (init_seq[k])
      wr(init_seq[k], {4'h0, init_seq[k], 20'h00c30});
    // Frequency change instead of the long wait, then register zero again
    wr(4'h3, 28'h0000011);
    wr(SSP_REG_R0, 28'h0000400);
    wr(SSP_REG_R0, 28'h0000400);
    stop_test();
  end
endmodule
